/* design/ppp_port_pins.sv */
// Printer port status and control pins shared with the floppy drive
//
// Functional notes
// - Bit 4 of the status register reads the printer-selected pin.
// - Bit 5 of the status register reads the paper-out pin.
// - Bit 7 of the status register reads the busy pin inverted.
// - Bit 6 of the status register reads the acknowledge pin as is.
// - Bit 3 of the status register reads the error pin as is.
// - The autofeed pin is driven as the inverse of control bit 1.
// - The strobe pin is driven as the inverse of control bit 0.
// - Software pulses control bit 0 to latch data with a low strobe.
`timescale 1ns/100ps
`default_nettype none

module ppp_port_pins (
	input  wire logic                      CLK,
	input  wire logic                      RESET,
	input  wire ppp_pkg::ppp_bus_s         BUS,
	output var  logic [7:0]                RDATA,
	output var  logic                      IRQ,
	input  wire ppp_pkg::ppp_prn_s         PIN_IN,
	input  wire ppp_pkg::ppp_fdc_s         FDC_OUT,
	output var  logic [ppp_pkg::NPINS-1:0] PIN_OUT,
	output var  logic [ppp_pkg::NPINS-1:0] PIN_OE
);

	logic [7:0]              ctrl_r;
	logic [7:0]              mode_r;
	logic [7:0]              mask_r;
	ppp_pkg::ppp_prn_s       prev_r;
	logic [ppp_pkg::NEV-1:0] ev_stat;
	logic                    irq_w;

	wire floppy   = mode_r[ppp_pkg::MD_FLOPPY];
	wire open_drn = mode_r[ppp_pkg::MD_OPEN];

	wire wr_ctrl = BUS.wr && (BUS.addr == ppp_pkg::ADDR_CONTROL);
	wire wr_mode = BUS.wr && (BUS.addr == ppp_pkg::ADDR_MODE);
	wire wr_mask = BUS.wr && (BUS.addr == ppp_pkg::ADDR_MASK);
	wire rd_ev   = BUS.rd && (BUS.addr == ppp_pkg::ADDR_EVENT);

	// Status byte straight from the pins; idle in floppy mode
	logic [7:0] status_w;
	assign status_w = floppy ? 8'h00 : {
		~PIN_IN.busy_in,
		PIN_IN.printer_ack_n_in,
		PIN_IN.paper_out_in,
		PIN_IN.select_in,
		PIN_IN.printer_fault_n_in,
		3'h0};

	logic [7:0] rd_mux;
	assign rd_mux =
		(BUS.addr == ppp_pkg::ADDR_STATUS)  ? status_w :
		(BUS.addr == ppp_pkg::ADDR_CONTROL) ? ctrl_r :
		(BUS.addr == ppp_pkg::ADDR_MODE)    ? mode_r :
		(BUS.addr == ppp_pkg::ADDR_EVENT)   ? {3'h0, ev_stat} :
		(BUS.addr == ppp_pkg::ADDR_MASK)    ? mask_r : 8'h00;

	// Printer events, only watched while the port owns the pins
	logic [ppp_pkg::NEV-1:0] ev_w;
	assign ev_w[ppp_pkg::EV_ACK] = !floppy
		&& prev_r.printer_ack_n_in && !PIN_IN.printer_ack_n_in;
	assign ev_w[ppp_pkg::EV_FAULT] = !floppy
		&& prev_r.printer_fault_n_in && !PIN_IN.printer_fault_n_in;
	assign ev_w[ppp_pkg::EV_PAPER] = !floppy
		&& !prev_r.paper_out_in && PIN_IN.paper_out_in;
	assign ev_w[ppp_pkg::EV_READY] = !floppy
		&& prev_r.busy_in && !PIN_IN.busy_in;
	assign ev_w[ppp_pkg::EV_SELECT] = !floppy
		&& prev_r.select_in && !PIN_IN.select_in;

	// Next pin drive: port mode versus floppy mode
	logic [ppp_pkg::NPINS-1:0] out_nxt;
	logic [ppp_pkg::NPINS-1:0] oe_nxt;
	logic [ppp_pkg::NPINS-1:0] fdc_vec;
	logic                      feed_nxt;
	logic                      latch_nxt;

	assign fdc_vec = FDC_OUT;
	assign feed_nxt  = ~ctrl_r[ppp_pkg::CT_FEED];
	assign latch_nxt = ~ctrl_r[ppp_pkg::CT_LATCH];

	assign out_nxt = floppy ? fdc_vec :
		{latch_nxt, feed_nxt, 5'h00};
	assign oe_nxt = floppy ? ~fdc_vec :
		open_drn ? {~latch_nxt, ~feed_nxt, 5'h00} : 7'h60;

	ppp_evt_irq #(
		.W (ppp_pkg::NEV)
	) u_evt (
		.clk   (CLK),
		.reset (RESET),
		.ev    (ev_w),
		.clr   (rd_ev),
		.mask  (mask_r[ppp_pkg::NEV-1:0]),
		.stat  (ev_stat),
		.irq   (irq_w)
	);

	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			ctrl_r <= ppp_pkg::CONTROL_RST;
			mode_r <= ppp_pkg::MODE_RST;
			mask_r <= ppp_pkg::MASK_RST;
		end else begin
			if (wr_ctrl) begin
				ctrl_r <= BUS.wdata;
			end
			if (wr_mode) begin
				mode_r <= {6'h00, BUS.wdata[1:0]};
			end
			if (wr_mask) begin
				mask_r <= {3'h0, BUS.wdata[ppp_pkg::NEV-1:0]};
			end
		end
	end

	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			RDATA <= ppp_pkg::RDATA_RST;
			prev_r <= '1;
		end else begin
			RDATA <= BUS.rd ? rd_mux : 8'h00;
			prev_r <= PIN_IN;
		end
	end

	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			PIN_OUT <= 7'h60;
			PIN_OE  <= 7'h60;
			IRQ     <= 1'b0;
		end else begin
			PIN_OUT <= out_nxt;
			PIN_OE  <= oe_nxt;
			IRQ     <= irq_w;
		end
	end

	select_read_a: assert property (@(posedge CLK) disable iff (RESET)
		(BUS.rd && BUS.addr == ppp_pkg::ADDR_STATUS && !floppy)
		|=> RDATA[ppp_pkg::ST_SELECT] == $past(PIN_IN.select_in))
		else $error("selected bit wrong");

	paper_read_a: assert property (@(posedge CLK) disable iff (RESET)
		(BUS.rd && BUS.addr == ppp_pkg::ADDR_STATUS && !floppy)
		|=> RDATA[ppp_pkg::ST_PAPER] == $past(PIN_IN.paper_out_in))
		else $error("paper-out bit wrong");

	busy_read_a: assert property (@(posedge CLK) disable iff (RESET)
		(BUS.rd && BUS.addr == ppp_pkg::ADDR_STATUS && !floppy)
		|=> RDATA[ppp_pkg::ST_READY] != $past(PIN_IN.busy_in))
		else $error("busy bit not inverted");

	ack_read_a: assert property (@(posedge CLK) disable iff (RESET)
		(BUS.rd && BUS.addr == ppp_pkg::ADDR_STATUS && !floppy)
		|=> RDATA[ppp_pkg::ST_ACK] == $past(PIN_IN.printer_ack_n_in))
		else $error("acknowledge bit wrong");

	fault_read_a: assert property (@(posedge CLK) disable iff (RESET)
		(BUS.rd && BUS.addr == ppp_pkg::ADDR_STATUS && !floppy)
		|=> RDATA[ppp_pkg::ST_FAULT] == $past(PIN_IN.printer_fault_n_in))
		else $error("error bit wrong");

	feed_pin_a: assert property (@(posedge CLK) disable iff (RESET)
		(wr_ctrl && !floppy && !wr_mode) ##1 !floppy
		|=> PIN_OUT[ppp_pkg::PIN_FEED] == !$past(BUS.wdata[1], 2))
		else $error("autofeed pin not inverse of control bit");

	latch_pin_a: assert property (@(posedge CLK) disable iff (RESET)
		(wr_ctrl && !floppy && !wr_mode) ##1 !floppy
		|=> PIN_OUT[ppp_pkg::PIN_LATCH] == !$past(BUS.wdata[0], 2))
		else $error("strobe pin not inverse of control bit");

	latch_pulse_a: assert property (@(posedge CLK) disable iff (RESET)
		(!floppy && !open_drn && ctrl_r[ppp_pkg::CT_LATCH])
		|=> (!PIN_OUT[ppp_pkg::PIN_LATCH] && PIN_OE[ppp_pkg::PIN_LATCH]))
		else $error("strobe not driven low");

	open_drain_oe_a: assert property (@(posedge CLK) disable iff (RESET)
		(!floppy && open_drn)
		|=> PIN_OE[6:5] == ~PIN_OUT[6:5])
		else $error("open-drain enable not tied to low level");

	floppy_route_a: assert property (@(posedge CLK) disable iff (RESET)
		floppy |=> (PIN_OUT == $past(fdc_vec))
			&& (PIN_OE == ~$past(fdc_vec)))
		else $error("floppy outputs not routed");

	floppy_status_a: assert property (@(posedge CLK) disable iff (RESET)
		(BUS.rd && BUS.addr == ppp_pkg::ADDR_STATUS && floppy)
		|=> RDATA == 8'h00)
		else $error("status not idle in floppy mode");

endmodule : ppp_port_pins

`default_nettype wire

/* design/ppp_pkg.sv */
// Constants and carrier types for the printer port pin block
package ppp_pkg;

	localparam int ADDR_W = 3;
	localparam int DATA_W = 8;

	localparam logic [2:0] ADDR_STATUS  = 3'h0;
	localparam logic [2:0] ADDR_CONTROL = 3'h1;
	localparam logic [2:0] ADDR_MODE    = 3'h2;
	localparam logic [2:0] ADDR_EVENT   = 3'h3;
	localparam logic [2:0] ADDR_MASK    = 3'h4;

	localparam int ST_FAULT  = 3;
	localparam int ST_SELECT = 4;
	localparam int ST_PAPER  = 5;
	localparam int ST_ACK    = 6;
	localparam int ST_READY  = 7;

	localparam int CT_LATCH = 0;
	localparam int CT_FEED  = 1;

	localparam int MD_FLOPPY = 0;
	localparam int MD_OPEN   = 1;

	localparam logic [7:0] CONTROL_RST = 8'h00;
	localparam logic [7:0] MODE_RST    = 8'h00;
	localparam logic [7:0] MASK_RST    = 8'h00;
	localparam logic [7:0] RDATA_RST   = 8'h00;

	localparam int PIN_SLCT  = 0;
	localparam int PIN_PE    = 1;
	localparam int PIN_BUSY  = 2;
	localparam int PIN_ACK   = 3;
	localparam int PIN_ERR   = 4;
	localparam int PIN_FEED  = 5;
	localparam int PIN_LATCH = 6;
	localparam int NPINS     = 7;

	localparam int EV_ACK    = 0;
	localparam int EV_FAULT  = 1;
	localparam int EV_PAPER  = 2;
	localparam int EV_READY  = 3;
	localparam int EV_SELECT = 4;
	localparam int NEV       = 5;

	typedef struct packed {
		logic select_in;
		logic paper_out_in;
		logic busy_in;
		logic printer_ack_n_in;
		logic printer_fault_n_in;
	} ppp_prn_s;

	typedef struct packed {
		logic drive_sel0_n;
		logic density_sel0_n;
		logic floppy_head_sel_n;
		logic floppy_drive_sel1_n;
		logic floppy_motor1_n;
		logic write_data_n;
		logic write_gate_n;
	} ppp_fdc_s;

	typedef struct packed {
		logic [2:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} ppp_bus_s;

endpackage : ppp_pkg

/* design/ppp_evt_irq.sv */
// Sticky event flags, mask and level interrupt
`timescale 1ns/100ps
`default_nettype none

module ppp_evt_irq #(
	parameter int W = 5
) (
	input  wire logic         clk,
	input  wire logic         reset,
	input  wire logic [W-1:0] ev,
	input  wire logic         clr,
	input  wire logic [W-1:0] mask,
	output var  logic [W-1:0] stat,
	output var  logic         irq
);

	logic [W-1:0] stat_nxt;

	// An event in the clearing cycle survives the clear
	assign stat_nxt = (stat & ~{W{clr}}) | ev;

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			stat <= '0;
			irq  <= 1'b0;
		end else begin
			stat <= stat_nxt;
			irq  <= |(stat_nxt & mask);
		end
	end

	set_wins_a: assert property (@(posedge clk) disable iff (reset)
		(ev != '0) |=> ((stat & $past(ev)) == $past(ev)))
		else $error("event lost in clearing cycle");

	irq_level_a: assert property (@(posedge clk) disable iff (reset)
		irq == |(stat & $past(mask)))
		else $error("interrupt level does not follow flags");

endmodule : ppp_evt_irq

`default_nettype wire

/* sim/ppp_printer.sv */
// Behavioural printer model on the far side of the port pins
`timescale 1ns/100ps
`default_nettype none

module ppp_printer (
	input  wire logic clk,
	input  wire logic reset,
	input  wire logic latch_n,
	input  wire logic slow,
	input  wire logic feed_n,
	output wire logic busy,
	output wire logic ack_n,
	output var  int   feeds
);
	logic busy_r = 1'b0;
	logic ack_r  = 1'b1;
	int   cnt    = 0;

	assign busy  = busy_r;
	assign ack_n = ack_r;

	always @(posedge clk or posedge reset) begin
		if (reset) begin
			busy_r <= 1'b0;
			ack_r <= 1'b1;
			cnt <= 0;
			feeds <= 0;
		end else if (!latch_n && !busy_r) begin
			busy_r <= 1'b1;
			cnt <= slow ? 30 : 8;
		end else if (cnt > 2) begin
			cnt <= cnt - 1;
		end else if (cnt > 0) begin
			ack_r <= 1'b0;
			cnt <= cnt - 1;
		end else if (!ack_r) begin
			ack_r <= 1'b1;
			busy_r <= 1'b0;
			if (!feed_n)
				feeds <= feeds + 1;
		end
	end
endmodule : ppp_printer
`default_nettype wire

/* sim/ppp_port_pins_bench.sv */
// Self-checking bench for the printer port pin block
`timescale 1ns/100ps
`default_nettype none

module ppp_port_pins_bench;
	logic              clk = 1'b0;
	logic              reset = 1'b1;
	ppp_pkg::ppp_bus_s bus = '0;
	ppp_pkg::ppp_fdc_s fdc = '0;
	logic              sel = 1'b1;
	logic              paper = 1'b0;
	logic              fault_n = 1'b1;
	logic              slow = 1'b0;
	logic              busy, ack_n, irq, latch_n;
	logic [7:0]        rdata, v, c;
	logic [6:0]        pin_out, pin_oe;
	int                failures = 0;
	int                n_checks = 0;
	int                feeds, f0;
	logic              feed_n;

	always #25 clk = ~clk;
	assign latch_n = pin_oe[6] ? pin_out[6] : 1'b1;
	assign feed_n  = pin_oe[5] ? pin_out[5] : 1'b1;

	ppp_port_pins ppp_port_pins_i (.CLK(clk), .RESET(reset), .BUS(bus),
		.RDATA(rdata), .IRQ(irq), .PIN_IN({sel, paper, busy, ack_n, fault_n}),
		.FDC_OUT(fdc), .PIN_OUT(pin_out), .PIN_OE(pin_oe));
	ppp_printer ppp_printer_i (.clk(clk), .reset(reset), .latch_n(latch_n),
		.slow(slow), .feed_n(feed_n), .busy(busy), .ack_n(ack_n),
		.feeds(feeds));

	function automatic logic [7:0] exp_status(input logic [4:0] p);
		return {~p[2], p[1], p[3], p[4], p[0], 3'h0};
	endfunction : exp_status

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk);
		bus <= '{a, d, 1'b1, 1'b0};
		@(posedge clk);
		bus.wr <= 1'b0;
	endtask : wr

	task automatic rd(input logic [2:0] a, output logic [7:0] d);
		@(posedge clk);
		bus <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge clk);
		bus.rd <= 1'b0;
		#1 d = rdata;
	endtask : rd

	task automatic strobe;
		wr(ppp_pkg::ADDR_CONTROL, 8'h01);
		wr(ppp_pkg::ADDR_CONTROL, 8'h00);
	endtask : strobe

	task automatic report_and_stop;
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : report_and_stop

	initial begin
		repeat (6000) @(posedge clk);
		failures++;
		report_and_stop();
	end

	initial begin
		void'($urandom(32'haab0));
		repeat (12) @(posedge clk);
		reset <= 1'b0;
		#1 chk({1'b0, pin_out}, 8'h60);
		chk({1'b0, pin_oe}, 8'h60);
		$display("reset test done");
		for (int i = 0; i < 12; i++) begin
			@(posedge clk);
			{sel, paper, fault_n} <= 3'($urandom);
			repeat (3) @(posedge clk);
			rd(ppp_pkg::ADDR_STATUS, v);
			chk(v, exp_status({sel, paper, busy, ack_n, fault_n}));
		end
		$display("status test done");
		for (int i = 0; i < 8; i++) begin
			c = (i < 4) ? 8'(i) : 8'($urandom);
			wr(ppp_pkg::ADDR_CONTROL, c);
			rd(ppp_pkg::ADDR_CONTROL, v);
			chk(v, c);
			chk({1'b0, pin_out}, {1'b0, ~c[0], ~c[1], 5'h00});
		end
		wr(ppp_pkg::ADDR_CONTROL, 8'h00);
		$display("control test done");
		repeat (40) @(posedge clk);
		wr(ppp_pkg::ADDR_MASK, 8'h01);
		rd(ppp_pkg::ADDR_EVENT, v);
		slow <= 1'b1;
		strobe();
		rd(ppp_pkg::ADDR_STATUS, v);
		chk(v & 8'hc0, 8'h40);
		for (int k = 0; k < 100 && irq !== 1'b1; k++) @(posedge clk);
		chk({7'h00, irq}, 8'h01);
		repeat (4) @(posedge clk);
		rd(ppp_pkg::ADDR_EVENT, v);
		chk(v & 8'h09, 8'h09);
		rd(ppp_pkg::ADDR_EVENT, v);
		chk(v, 8'h00);
		repeat (2) @(posedge clk);
		chk({7'h00, irq}, 8'h00);
		wr(ppp_pkg::ADDR_MASK, 8'h00);
		slow <= 1'b0;
		strobe();
		repeat (30) @(posedge clk);
		chk({7'h00, irq}, 8'h00);
		rd(ppp_pkg::ADDR_EVENT, v);
		chk(v & 8'h09, 8'h09);
		$display("interrupt test done");
		f0 = feeds;
		wr(ppp_pkg::ADDR_MODE, 8'h02);
		wr(ppp_pkg::ADDR_CONTROL, 8'h03);
		rd(ppp_pkg::ADDR_CONTROL, v);
		chk({1'b0, pin_oe}, 8'h60);
		chk({1'b0, pin_out}, 8'h00);
		wr(ppp_pkg::ADDR_CONTROL, 8'h02);
		repeat (30) @(posedge clk);
		chk(8'(feeds - f0), 8'h01);
		wr(ppp_pkg::ADDR_CONTROL, 8'h00);
		rd(ppp_pkg::ADDR_CONTROL, v);
		chk({1'b0, pin_oe}, 8'h00);
		$display("open-drain test done");
		wr(ppp_pkg::ADDR_MODE, 8'h01);
		for (int i = 0; i < 6; i++) begin
			@(posedge clk);
			fdc <= 7'($urandom);
			if (i == 5)
				wr(ppp_pkg::ADDR_CONTROL, 8'h03);
			repeat (3) @(posedge clk);
			chk({1'b0, pin_out}, {1'b0, fdc});
			chk({1'b0, pin_oe}, {1'b0, ~fdc});
		end
		rd(ppp_pkg::ADDR_STATUS, v);
		chk(v, 8'h00);
		rd(3'h5, v);
		chk(v, 8'h00);
		$display("floppy and unmapped test done");
		report_and_stop();
	end
endmodule : ppp_port_pins_bench
`default_nettype wire
